// ===== src/clb_defs.svh
// Constants of the programmable logic block: sizes, product-term indices and select codes.
// Assumes inclusion by bare name from the block's design files.
`ifndef CLB_DEFS_SVH
`define CLB_DEFS_SVH

`define CLB_ROUTE_INPUTS 36
`define CLB_FIELD_WIDTH 72
`define CLB_TERMS 87
`define CLB_GP_TERMS 80
`define CLB_MACROCELLS 16
`define CLB_HALF_MACROCELLS 8
`define CLB_TERMS_PER_MC 16
`define CLB_STEER_STRIDE 5
`define CLB_OE_TERM_BASE 80
`define CLB_SET_TERM 84
`define CLB_RESET_TERM 85
`define CLB_BLOCK_TERM_CLOCK_TERM 86
`define CLB_GLOBAL_CLOCKS 4
`define CLB_INPUT_CELLS 5
`define CLB_CLKSEL_PTERM 3'h4
`define CLB_CLK_INDEX_PTERM 3'h4

`endif

// ===== src/clb_logic_block.sv
// Programmable logic block: product-term array, allocator, sixteen macrocells, I/O and input cells.
// Assumes ROUTE_IN and all CFG_* ports come from MCLK logic; clock and I/O pins are asynchronous.
`timescale 1ns/1ns
`default_nettype none
`include "clb_defs.svh"
module clb_logic_block
    import clb_pkg::*;
(
    input wire logic MCLK,
    input wire logic RESETN,
    input wire logic [35:0] ROUTE_IN,
    input wire logic [6263:0] CFG_AND_ARRAY,
    input wire logic [255:0] CFG_STEER,
    input wire logic [31:0] CFG_MODE,
    input wire logic [47:0] CFG_CLK_SEL,
    input wire logic [15:0] CFG_OE_SEL,
    input wire logic [3:0] CFG_OE_INV,
    input wire logic CFG_SET_INV,
    input wire logic CFG_RESET_INV,
    input wire logic CFG_BLOCK_TERM_CLOCK_INV,
    input wire logic CFG_CLK_INV,
    input wire logic CFG_LOW_POWER,
    input wire logic [15:0] CFG_BURIED,
    input wire logic [15:0] CFG_INPUT_REG,
    input wire logic [15:0] CFG_OUT_INV,
    input wire logic [3:0] CFG_CLKPIN_INV,
    input wire logic [9:0] CFG_IN_MODE,
    input wire logic [9:0] CFG_IN_CLK_SEL,
    input wire logic GLOBAL_CLOCK_A,
    input wire logic GLOBAL_CLOCK_B,
    input wire logic GLOBAL_CLOCK_C,
    input wire logic GLOBAL_CLOCK_D,
    input wire logic DEDICATED_IN,
    input wire logic [15:0] PIN_IN,
    output logic [15:0] PIN_OUT,
    output logic [15:0] PIN_OE,
    output logic [15:0] PIN_KEEP_OUT,
    output logic [15:0] PIN_KEEP_EN,
    output logic [15:0] MC_FEEDBACK,
    output logic [15:0] PIN_FEEDBACK,
    output logic [4:0] INPUT_CELL_OUT,
    output logic BLOCK_LOW_POWER
);

    // A term with no connected line reads high, as an unprogrammed AND does.
    function automatic logic term_and(input logic [71:0] field, input logic [71:0] mask);
        term_and = &(field | ~mask);
    endfunction

    // Maps a 3-bit clock select onto the five-entry clock vector; input registers see only globals.
    function automatic logic [2:0] clk_index(input logic [2:0] sel, input logic globals_only);
        if (!globals_only && sel == `CLB_CLKSEL_PTERM)
        begin
            clk_index = `CLB_CLK_INDEX_PTERM;
        end
        else if (sel > `CLB_CLKSEL_PTERM)
        begin
            clk_index = 3'h0;
        end
        else
        begin
            clk_index = {1'b0, sel[1:0]};
        end
    endfunction

    logic rst_s1_q;
    logic rst_n_q;
    logic [4:0] in_s1_q;
    logic [4:0] in_s2_q;
    logic [15:0] pin_s1_q;
    logic [15:0] pin_s2_q;
    logic [3:0] gclk;
    logic [3:0] gclk_prev_q;
    logic [3:0] gclk_edge;
    logic [4:0] blk_clk;
    logic [4:0] blk_clk_prev_q;
    logic [4:0] blk_edge;
    logic edge_arm_q;
    logic [71:0] field;
    logic [86:0] terms;
    logic [3:0] oe_term;
    logic set_term;
    logic reset_term;
    logic block_term_clock;
    logic [15:0] mc_sum;
    logic [15:0] mc_q;
    logic [15:0] mc_oe;
    logic [15:0] pin_out_q;
    logic [15:0] pin_oe_q;
    logic [15:0] keep_q;
    logic [15:0] feedback_q;
    logic [15:0] pin_fb_q;
    logic [4:0] stage1_q;
    logic [4:0] stage2_q;
    logic [4:0] in_out_q;
    logic low_power_q;

    // Reset is asserted at once and released through two flops.
    always_ff @(posedge MCLK or negedge RESETN)
    begin
        if (!RESETN)
        begin
            rst_s1_q <= 1'b0;
            rst_n_q <= 1'b0;
        end
        else
        begin
            rst_s1_q <= 1'b1;
            rst_n_q <= rst_s1_q;
        end
    end

    // Clock/input pins and I/O pins are asynchronous to MCLK.
    always_ff @(posedge MCLK or negedge rst_n_q)
    begin
        if (!rst_n_q)
        begin
            in_s1_q <= 5'h00;
            in_s2_q <= 5'h00;
            pin_s1_q <= 16'h0000;
            pin_s2_q <= 16'h0000;
        end
        else
        begin
            in_s1_q <= {DEDICATED_IN, GLOBAL_CLOCK_D, GLOBAL_CLOCK_C, GLOBAL_CLOCK_B, GLOBAL_CLOCK_A};
            in_s2_q <= in_s1_q;
            pin_s1_q <= PIN_IN;
            pin_s2_q <= pin_s1_q;
        end
    end

    assign gclk = in_s2_q[3:0] ^ CFG_CLKPIN_INV;
    // Edges are ignored until the history flops hold a real sample, so an inverted clock cannot fake one.
    assign gclk_edge = gclk & ~gclk_prev_q & {4{edge_arm_q}};

    assign field = {~ROUTE_IN, ROUTE_IN};

    genvar t;
    generate
        for (t = 0; t < `CLB_TERMS; t++)
        begin : g_term
            assign terms[t] = term_and(field, CFG_AND_ARRAY[t*`CLB_FIELD_WIDTH +: `CLB_FIELD_WIDTH]);
        end
    endgenerate

    assign oe_term = terms[`CLB_OE_TERM_BASE +: 4] ^ CFG_OE_INV;
    assign set_term = terms[`CLB_SET_TERM] ^ CFG_SET_INV;
    assign reset_term = terms[`CLB_RESET_TERM] ^ CFG_RESET_INV;
    assign block_term_clock = terms[`CLB_BLOCK_TERM_CLOCK_TERM] ^ CFG_BLOCK_TERM_CLOCK_INV;

    // Global clocks take the block-wide inversion; the term clock has its own polarity.
    assign blk_clk = {block_term_clock, gclk ^ {4{CFG_CLK_INV}}};
    assign blk_edge = blk_clk & ~blk_clk_prev_q & {5{edge_arm_q}};

    always_ff @(posedge MCLK or negedge rst_n_q)
    begin
        if (!rst_n_q)
        begin
            gclk_prev_q <= 4'h0;
            blk_clk_prev_q <= 5'h00;
            edge_arm_q <= 1'b0;
        end
        else
        begin
            gclk_prev_q <= gclk;
            blk_clk_prev_q <= blk_clk;
            edge_arm_q <= 1'b1;
        end
    end

    genvar i;
    generate
        for (i = 0; i < `CLB_MACROCELLS; i++)
        begin : g_mc
            // Windows of neighbouring macrocells overlap, so one term can feed several of them.
            localparam int BASE = (`CLB_STEER_STRIDE * i > `CLB_GP_TERMS - `CLB_TERMS_PER_MC) ?
                (`CLB_GP_TERMS - `CLB_TERMS_PER_MC) : `CLB_STEER_STRIDE * i;
            logic input_reg;
            logic [2:0] cidx;
            logic data;
            clb_mc_mode_t cfg_mode;
            clb_mc_mode_t mode_eff;

            assign mc_sum[i] = |(terms[BASE +: `CLB_TERMS_PER_MC] & CFG_STEER[i*16 +: 16]);
            assign input_reg = CFG_INPUT_REG[i] & CFG_BURIED[i];
            assign data = input_reg ? pin_s2_q[i ^ 1] : mc_sum[i];
            assign cfg_mode = clb_mc_mode_t'(CFG_MODE[2*i +: 2]);
            assign mode_eff = (input_reg && cfg_mode != MC_LATCH) ? MC_DFF : cfg_mode;
            assign cidx = clk_index(CFG_CLK_SEL[3*i +: 3], input_reg);
            assign mc_oe[i] = (i < `CLB_HALF_MACROCELLS) ? oe_term[{1'b0, CFG_OE_SEL[i]}] :
                oe_term[{1'b1, CFG_OE_SEL[i]}];

            clb_macrocell u_mc (
                .clk(MCLK),
                .rst_n(rst_n_q),
                .mode(mode_eff),
                .logic_in(data),
                .cap_edge(blk_edge[cidx]),
                .cap_level(blk_clk[cidx]),
                .set_term(set_term),
                .reset_term(reset_term),
                .q(mc_q[i])
            );
        end
    endgenerate

    // Every allocation goes through the same single output stage, so latency never varies.
    always_ff @(posedge MCLK or negedge rst_n_q)
    begin
        if (!rst_n_q)
        begin
            pin_out_q <= 16'h0000;
            pin_oe_q <= 16'h0000;
            feedback_q <= 16'h0000;
        end
        else
        begin
            pin_out_q <= ~CFG_BURIED & (mc_q ^ CFG_OUT_INV);
            pin_oe_q <= ~CFG_BURIED & mc_oe;
            feedback_q <= mc_q;
        end
    end

    // The keeper copies the driven level, or the sensed level while the driver is off.
    always_ff @(posedge MCLK or negedge rst_n_q)
    begin
        if (!rst_n_q)
        begin
            keep_q <= 16'h0000;
            pin_fb_q <= 16'h0000;
        end
        else
        begin
            keep_q <= (pin_oe_q & pin_out_q) | (~pin_oe_q & pin_s2_q);
            pin_fb_q <= pin_s2_q;
        end
    end

    genvar c;
    generate
        for (c = 0; c < `CLB_INPUT_CELLS; c++)
        begin : g_in
            clb_in_mode_t imode;
            logic [1:0] isel;

            assign imode = clb_in_mode_t'(CFG_IN_MODE[2*c +: 2]);
            assign isel = CFG_IN_CLK_SEL[2*c +: 2];

            always_ff @(posedge MCLK or negedge rst_n_q)
            begin
                if (!rst_n_q)
                begin
                    stage1_q[c] <= 1'b0;
                    stage2_q[c] <= 1'b0;
                    in_out_q[c] <= 1'b0;
                end
                else
                begin
                    if ((imode == IN_LATCH) ? gclk[isel] : gclk_edge[isel])
                    begin
                        stage1_q[c] <= in_s2_q[c];
                    end
                    if (gclk_edge[isel])
                    begin
                        stage2_q[c] <= stage1_q[c];
                    end
                    unique case (imode)
                        IN_COMB: in_out_q[c] <= in_s2_q[c];
                        IN_REG: in_out_q[c] <= stage1_q[c];
                        IN_DREG: in_out_q[c] <= stage2_q[c];
                        IN_LATCH: in_out_q[c] <= stage1_q[c];
                    endcase
                end
            end
        end
    endgenerate

    always_ff @(posedge MCLK or negedge rst_n_q)
    begin
        if (!rst_n_q)
        begin
            low_power_q <= 1'b0;
        end
        else
        begin
            low_power_q <= CFG_LOW_POWER;
        end
    end

    assign PIN_OUT = pin_out_q;
    assign PIN_OE = pin_oe_q;
    assign PIN_KEEP_OUT = keep_q;
    assign PIN_KEEP_EN = ~pin_oe_q;
    assign MC_FEEDBACK = feedback_q;
    assign PIN_FEEDBACK = pin_fb_q;
    assign INPUT_CELL_OUT = in_out_q;
    assign BLOCK_LOW_POWER = low_power_q;

endmodule
`default_nettype wire

// ===== src/clb_macrocell.sv
// One macrocell storage element: pass-through, D, T or latch; block set and reset act in all but pass-through.
// Assumes capture strobes and set/reset terms are already on the MCLK domain.
`timescale 1ns/1ns
`default_nettype none
module clb_macrocell
    import clb_pkg::*;
(
    input wire logic clk,
    input wire logic rst_n,
    input wire clb_mc_mode_t mode,
    input wire logic logic_in,
    input wire logic cap_edge,
    input wire logic cap_level,
    input wire logic set_term,
    input wire logic reset_term,
    output logic q
);

    logic q_q;

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            q_q <= 1'b0;
        end
        else if (mode == MC_COMB)
        begin
            q_q <= logic_in;
        end
        else if (reset_term)
        begin
            q_q <= 1'b0;
        end
        else if (set_term)
        begin
            q_q <= 1'b1;
        end
        else
        begin
            unique case (mode)
                MC_DFF:
                begin
                    if (cap_edge)
                    begin
                        q_q <= logic_in;
                    end
                end
                MC_TFF:
                begin
                    if (cap_edge && logic_in)
                    begin
                        q_q <= ~q_q;
                    end
                end
                MC_LATCH:
                begin
                    if (cap_level)
                    begin
                        q_q <= logic_in;
                    end
                end
                MC_COMB:
                begin
                    q_q <= logic_in;
                end
            endcase
        end
    end

    assign q = q_q;

endmodule
`default_nettype wire

// ===== src/clb_pkg.sv
// Types shared by the programmable logic block and its macrocell.
// Assumes nothing of its surroundings.
package clb_pkg;

    typedef enum logic [1:0] {MC_COMB, MC_DFF, MC_TFF, MC_LATCH} clb_mc_mode_t;

    typedef enum logic [1:0] {IN_COMB, IN_REG, IN_DREG, IN_LATCH} clb_in_mode_t;

endpackage

// ===== verification/clb_logic_block_assertions.sv
// Port-level assertions for the logic block.
// Assumes MCLK and the active-low asynchronous RESETN of the block.
`timescale 1ns/1ns
`default_nettype none
module clb_logic_block_assertions (
    input wire logic MCLK,
    input wire logic RESETN,
    input wire logic [35:0] ROUTE_IN,
    input wire logic [6263:0] CFG_AND_ARRAY,
    input wire logic [255:0] CFG_STEER,
    input wire logic [31:0] CFG_MODE,
    input wire logic [15:0] CFG_OE_SEL,
    input wire logic [3:0] CFG_OE_INV,
    input wire logic CFG_RESET_INV,
    input wire logic CFG_LOW_POWER,
    input wire logic [15:0] CFG_BURIED,
    input wire logic [15:0] CFG_OUT_INV,
    input wire logic [15:0] PIN_OUT,
    input wire logic [15:0] PIN_OE,
    input wire logic [15:0] PIN_KEEP_EN,
    input wire logic [15:0] MC_FEEDBACK,
    input wire logic BLOCK_LOW_POWER
);
    default clocking cb @(posedge MCLK); endclocking
    default disable iff (!RESETN);
    logic [1:0] up_q;
    logic [15:0] oe_x;
    logic rdy;
    logic cfg0;
    // Outputs lag the synchronised reset release, so checks wait three edges.
    assign rdy = up_q == 2'h3;
    assign cfg0 = rdy && CFG_MODE[1:0] == 2'h0 && CFG_STEER[15:0] == 16'h1 && CFG_AND_ARRAY[71:0] == 72'h1;
    always_ff @(posedge MCLK or negedge RESETN)
        if (!RESETN)
            up_q <= 2'h0;
        else if (!rdy)
            up_q <= up_q + 2'h1;
    always_comb
        for (int i = 0; i < 16; i++)
            oe_x[i] = ~CFG_BURIED[i] & ~CFG_OE_INV[{i[3], CFG_OE_SEL[i]}];

    keeper_mirror_a: assert property (PIN_KEEP_EN == ~PIN_OE)
        else $error("keeper enable differs");
    reset_outputs_a: assert property (disable iff (1'b0)
        !RESETN |-> PIN_OE == 16'h0 && PIN_KEEP_EN == 16'hffff && MC_FEEDBACK == 16'h0)
        else $error("outputs not cleared in reset");
    low_power_a: assert property (rdy |-> BLOCK_LOW_POWER == $past(CFG_LOW_POWER))
        else $error("power mode flag wrong");
    out_polarity_a: assert property ((rdy && $stable(CFG_OUT_INV) && $stable(CFG_BURIED))[*3]
        |-> PIN_OUT == ((MC_FEEDBACK ^ CFG_OUT_INV) & ~CFG_BURIED))
        else $error("pin polarity wrong");
    oe_select_a: assert property ((rdy && CFG_AND_ARRAY[6047:5760] == 288'h0 && $stable(oe_x))[*3]
        |-> PIN_OE == oe_x)
        else $error("output enable choice wrong");
    zero_terms_a: assert property ((rdy && CFG_STEER[15:0] == 16'h0 && CFG_MODE[1:0] == 2'h0)[*3]
        |-> !MC_FEEDBACK[0])
        else $error("empty sum not zero");
    comb_path_a: assert property (cfg0[*3] |-> MC_FEEDBACK[0] == $past(ROUTE_IN[0], 2))
        else $error("comb latency wrong");
    reset_wins_a: assert property (
        (rdy && CFG_MODE[3:2] == 2'h1 && CFG_AND_ARRAY[6191:6120] == 72'h0 && !CFG_RESET_INV)[*3]
        |-> !MC_FEEDBACK[1])
        else $error("reset term lost");
    comb_seen_c: cover property (cfg0[*3]);
    reset_seen_c: cover property (rdy && !CFG_RESET_INV);
    power_seen_c: cover property (rdy && BLOCK_LOW_POWER);
endmodule
`default_nettype wire

// ===== verification/clb_partner.sv
// Model of the routing matrix and the board side of the I/O pins.
// Assumes the bench supplies routed values and any outside pin drive.
`timescale 1ns/1ns
`default_nettype none
module clb_partner (
    input wire logic [15:0] PIN_OUT,
    input wire logic [15:0] PIN_OE,
    input wire logic [15:0] PIN_KEEP_OUT,
    input wire logic [15:0] PIN_KEEP_EN,
    input wire logic [15:0] MC_FEEDBACK,
    input wire logic [15:0] rt_drv,
    input wire logic [15:0] ext_val,
    input wire logic [15:0] ext_en,
    output logic [35:0] ROUTE_IN,
    output logic [15:0] PIN_IN
);
    assign ROUTE_IN = {4'h0, MC_FEEDBACK, rt_drv};
    // The block's driver wins, then an outside driver, then the weak keeper.
    always_comb
        for (int i = 0; i < 16; i++)
            PIN_IN[i] = PIN_OE[i] ? PIN_OUT[i] : ext_en[i] ? ext_val[i] : PIN_KEEP_EN[i] & PIN_KEEP_OUT[i];
endmodule
`default_nettype wire

// ===== verification/tb_top.sv
// Self-checking bench for the logic block with the routing and pin model.
// Assumes design, partner and checker are compiled before this file.
`timescale 1ns/1ns
`default_nettype none
`define CHK(n, e, a) begin samples_checked++; if ((a) !== (e)) begin fails++; \
    $display("CHECK FAILED %s exp %h got %h", n, e, a); end end
module tb_top;
    logic MCLK, RESETN, CFG_SET_INV, CFG_RESET_INV, CFG_BLOCK_TERM_CLOCK_INV, CFG_CLK_INV, CFG_LOW_POWER;
    logic GLOBAL_CLOCK_A, GLOBAL_CLOCK_B, GLOBAL_CLOCK_C, GLOBAL_CLOCK_D, DEDICATED_IN, BLOCK_LOW_POWER;
    logic [35:0] ROUTE_IN;
    logic [6263:0] CFG_AND_ARRAY;
    logic [255:0] CFG_STEER;
    logic [47:0] CFG_CLK_SEL;
    logic [31:0] CFG_MODE;
    logic [15:0] CFG_OE_SEL, CFG_BURIED, CFG_INPUT_REG, CFG_OUT_INV, PIN_IN, PIN_OUT, PIN_OE;
    logic [15:0] PIN_KEEP_OUT, PIN_KEEP_EN, MC_FEEDBACK, PIN_FEEDBACK, rt_drv, ext_val, ext_en, want;
    logic [9:0] CFG_IN_MODE, CFG_IN_CLK_SEL;
    logic [4:0] INPUT_CELL_OUT;
    logic [3:0] CFG_OE_INV, CFG_CLKPIN_INV;
    int fails = 0;
    int samples_checked = 0;

    clb_logic_block u_dut (.*);
    clb_partner u_far (.*);

    task automatic cyc(input int n);
        repeat (n) @(posedge MCLK);
        #1;
    endtask
    task automatic gclk(input logic v);
        {GLOBAL_CLOCK_A, GLOBAL_CLOCK_B, GLOBAL_CLOCK_C, GLOBAL_CLOCK_D} = {4{v}};
    endtask
    task automatic pulse;
        gclk(1'b1);
        cyc(4);
        gclk(1'b0);
        cyc(4);
    endtask
    // Set and reset terms read 1 with empty masks, so both are inverted off.
    task automatic base;
        {CFG_AND_ARRAY, CFG_STEER, CFG_MODE, CFG_CLK_SEL} = '0;
        {CFG_OE_SEL, CFG_BURIED, CFG_INPUT_REG, CFG_OUT_INV, CFG_OE_INV, CFG_CLKPIN_INV} = '0;
        {CFG_IN_MODE, CFG_IN_CLK_SEL, rt_drv, ext_val, ext_en} = '0;
        {CFG_SET_INV, CFG_RESET_INV, CFG_BLOCK_TERM_CLOCK_INV, CFG_CLK_INV, CFG_LOW_POWER} = 5'h18;
        cyc(3);
    endtask
    task automatic t_comb;
        base;
        CFG_AND_ARRAY[71:0] = 72'h1;
        CFG_STEER[15:0] = 16'h1;
        rt_drv[0] = 1'b1;
        cyc(1);
        `CHK("pin0 early", 1'b0, PIN_OUT[0])
        cyc(1);
        `CHK("pin0", 1'b1, PIN_OUT[0])
        CFG_OUT_INV[0] = 1'b1;
        cyc(3);
        `CHK("pin0 inv", 1'b0, PIN_OUT[0])
        CFG_AND_ARRAY[71:0] = 72'h1 << 36;
        cyc(3);
        `CHK("pin0 compl", 1'b1, PIN_OUT[0])
        $display("test comb done");
    endtask
    task automatic t_toggle;
        base;
        CFG_MODE[3:2] = 2'h2;
        CFG_CLK_SEL[5:3] = 3'h1;
        CFG_STEER[31:16] = 16'h1;
        for (int k = 1; k < 4; k++)
        begin
            pulse;
            `CHK("toggle", k[0], MC_FEEDBACK[1])
        end
        CFG_STEER[31:16] = 16'h0;
        pulse;
        `CHK("hold", 1'b1, MC_FEEDBACK[1])
        CFG_STEER[31:16] = 16'h1;
        CFG_CLK_SEL[5:3] = 3'h4;
        CFG_AND_ARRAY[6196] = 1'b1;
        cyc(3);
        rt_drv[4] = 1'b1;
        cyc(5);
        `CHK("term clock", 1'b0, MC_FEEDBACK[1])
        $display("test toggle done");
    endtask
    task automatic t_inv;
        base;
        CFG_MODE[3:2] = 2'h1;
        CFG_CLK_SEL[5:3] = 3'h1;
        CFG_STEER[31:16] = 16'h1;
        CFG_AND_ARRAY[362] = 1'b1;
        CFG_CLK_INV = 1'b1;
        rt_drv[2] = 1'b1;
        pulse;
        rt_drv[2] = 1'b0;
        gclk(1'b1);
        cyc(6);
        `CHK("rise ignored", 1'b1, MC_FEEDBACK[1])
        gclk(1'b0);
        cyc(6);
        `CHK("fall captures", 1'b0, MC_FEEDBACK[1])
        CFG_SET_INV = 1'b0;
        cyc(3);
        `CHK("set", 1'b1, MC_FEEDBACK[1])
        CFG_RESET_INV = 1'b0;
        cyc(3);
        `CHK("reset wins", 1'b0, MC_FEEDBACK[1])
        $display("test inversion done");
    endtask
    task automatic t_oe;
        base;
        CFG_BURIED = 16'h0003;
        for (int p = 0; p < 2; p++)
        begin
            CFG_OE_SEL = p ? 16'hf00f : 16'h00ff;
            CFG_OE_INV = p ? 4'h6 : 4'h5;
            cyc(3);
            for (int i = 0; i < 16; i++)
                want[i] = ~CFG_BURIED[i] & ~CFG_OE_INV[{i >= 8, CFG_OE_SEL[i]}];
            `CHK("oe", want, PIN_OE)
            `CHK("keep en", ~want, PIN_KEEP_EN)
        end
        CFG_AND_ARRAY[71:0] = 72'h1;
        CFG_STEER[15:0] = 16'h1;
        rt_drv[0] = 1'b1;
        cyc(3);
        `CHK("buried fb", 1'b1, MC_FEEDBACK[0])
        `CHK("buried pin", 1'b0, PIN_OUT[0])
        $display("test oe done");
    endtask
    task automatic t_power;
        base;
        for (int v = 1; v >= 0; v--)
        begin
            CFG_LOW_POWER = v[0];
            cyc(1);
            `CHK("low power", v[0], BLOCK_LOW_POWER)
        end
        $display("test power done");
    endtask
    task automatic t_incell;
        base;
        CFG_IN_MODE[9:8] = 2'h2;
        DEDICATED_IN = 1'b1;
        cyc(4);
        pulse;
        `CHK("dreg first", 1'b0, INPUT_CELL_OUT[4])
        pulse;
        `CHK("dreg second", 1'b1, INPUT_CELL_OUT[4])
        CFG_IN_MODE[9:8] = 2'h0;
        cyc(5);
        `CHK("comb in", 1'b1, INPUT_CELL_OUT[4])
        DEDICATED_IN = 1'b0;
        $display("test input cell done");
    endtask
    task automatic t_keep;
        base;
        CFG_AND_ARRAY[723] = 1'b1;
        CFG_STEER[47:32] = 16'h1;
        rt_drv[3] = 1'b1;
        cyc(4);
        CFG_OE_INV = 4'hf;
        cyc(4);
        `CHK("keeper", 1'b1, PIN_KEEP_OUT[2])
        `CHK("pin held", 1'b1, PIN_FEEDBACK[2])
        ext_en[2] = 1'b1;
        cyc(5);
        `CHK("pin low", 1'b0, PIN_FEEDBACK[2])
        `CHK("fb apart", 1'b1, MC_FEEDBACK[2])
        $display("test keeper done");
    endtask
    task automatic t_inreg;
        base;
        CFG_OE_INV = 4'hf;
        CFG_BURIED[3] = 1'b1;
        CFG_INPUT_REG[3] = 1'b1;
        CFG_MODE[7:6] = 2'h3;
        ext_en[2] = 1'b1;
        ext_val[2] = 1'b1;
        gclk(1'b1);
        cyc(6);
        `CHK("inreg open", 1'b1, MC_FEEDBACK[3])
        gclk(1'b0);
        cyc(6);
        ext_val[2] = 1'b0;
        cyc(6);
        `CHK("latch closed", 1'b1, MC_FEEDBACK[3])
        gclk(1'b1);
        cyc(6);
        `CHK("latch reopen", 1'b0, MC_FEEDBACK[3])
        CFG_CLKPIN_INV[0] = 1'b1;
        CFG_IN_MODE[9:8] = 2'h1;
        DEDICATED_IN = 1'b0;
        cyc(6);
        gclk(1'b0);
        cyc(6);
        gclk(1'b1);
        cyc(6);
        `CHK("reg cleared", 1'b0, INPUT_CELL_OUT[4])
        DEDICATED_IN = 1'b1;
        cyc(6);
        `CHK("reg holds", 1'b0, INPUT_CELL_OUT[4])
        gclk(1'b0);
        cyc(6);
        `CHK("inverted pin clock", 1'b1, INPUT_CELL_OUT[4])
        $display("test input register done");
    endtask
    task automatic summarize;
        $display("checks %0d mismatches %0d", samples_checked, fails);
        if (fails == 0 && samples_checked > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask

    initial
    begin
        MCLK = 1'b0;
        forever #25 MCLK = ~MCLK;
    end
    initial
    begin
        RESETN = 1'b0;
        DEDICATED_IN = 1'b0;
        gclk(1'b0);
        base;
        cyc(9);
        RESETN = 1'b1;
        cyc(3);
        t_comb;
        t_toggle;
        t_inv;
        t_oe;
        t_power;
        t_incell;
        t_keep;
        t_inreg;
        summarize;
    end
    // The tests need about 216 cycles; this allows about nine times that.
    initial
    begin
        #100000;
        fails++;
        summarize;
    end
endmodule
bind clb_logic_block clb_logic_block_assertions u_chk (.*);
`default_nettype wire
